// ---- hdl/adc_serial_command_decoder.v ----
// serial command decoder for a delta-sigma converter
`timescale 1ns/10ps
`default_nettype none
`include "cmd_decoder_regs.vh"
// Summary of operation
// [RULE_01] all-zero byte does nothing
// [RULE_02] decode wake, sleep, reset, start, stop
// [RULE_03] exact bytes start three calibrations; the code starts them only while converting
// [RULE_04] 0001001x requests latest result read
// [RULE_05] register read: address byte, count byte
// [RULE_06] register write: address, count, data bytes
// [RULE_07] no result load during register access
// [RULE_08] chip select high abandons unfinished command
// [RULE_09] wake leaves sleep into standby
// [RULE_10] host runs external clock before wake
// [RULE_11] sleep aborts conversion, enters two clocks later
// [RULE_12] host gives two clocks after sleep
// [RULE_13] asleep: only read, result read, wake
// [RULE_14] reset clears filter, defaults, oscillator, standby
// [RULE_15] continuous start repeats conversions until stop
// [RULE_16] single-shot start does exactly one conversion
// [RULE_17] start ignored if sync pin high/converting
// [RULE_18] stop finishes conversion; none in single-shot
// [RULE_19] system offset cal updates offset correction
// [RULE_20] system gain cal updates fullscale correction
// [RULE_21] self offset cal shorts inputs, updates offset
// [RULE_22] sample on falling edge, shift rising
// [RULE_23] reads past last register return zero
// [RULE_24] register access blocks commands until finished
// [RULE_25] unknown first bytes have no effect
module adc_serial_command_decoder #(
	parameter LAST_REG_ADDR = 5'h11,
	parameter TIMEOUT_CLKS = 32768
) (
	input wire clk_i, // 250 mhz system clock
	input wire reset_i, // synchronous reset, active high
	input wire cs_n_i, // chip select pin, active low
	input wire sclk_i, // serial clock pin
	input wire din_i, // serial data in pin
	input wire sync_pin_i, // start/synchronise pin level
	input wire single_shot_i, // 1 selects single-shot mode
	input wire timeout_en_i, // enables serial timeout
	input wire conv_done_i, // pulse: a conversion completed
	input wire [23:0] result_i, // conversion result word
	input wire [7:0] reg_rdata_i, // register data at reg_addr_o
	output reg serial_out_o, // serial data out level
	output reg serial_out_en_o, // drive enable for data out
	output reg reg_wr_o, // pulse: write reg_wdata_o
	output reg [4:0] reg_addr_o, // register address
	output reg [7:0] reg_wdata_o, // register write data
	output reg asleep_o, // device in sleep state
	output reg converting_o, // conversions running
	output reg conv_start_o, // pulse: begin a conversion
	output reg conv_abort_o, // pulse: abort conversion
	output reg filter_clear_o, // pulse: clear digital filter
	output reg defaults_load_o, // pulse: restore default config
	output reg int_osc_sel_o, // internal oscillator selected
	output reg cal_start_o, // pulse: begin calibration
	output reg [1:0] cal_type_o, // calibration kind
	output reg result_load_o // pulse: result to shift register
);
	localparam ST_CMD = 5'h01;
	localparam ST_COUNT = 5'h02;
	localparam ST_RDOUT = 5'h04;
	localparam ST_WRDATA = 5'h08;
	localparam ST_RESOUT = 5'h10;

	reg cs_m_reg;
	reg cs_s_reg;
	reg sclk_m_reg;
	reg sclk_s_reg;
	reg sclk_d_reg;
	reg din_m_reg;
	reg din_s_reg;
	// pin synchronisers; idle levels on reset so no false edge follows
	always @(posedge clk_i) begin
		if (reset_i) begin
			cs_m_reg <= 1'b1;
			cs_s_reg <= 1'b1;
			sclk_m_reg <= 1'b0;
			sclk_s_reg <= 1'b0;
			sclk_d_reg <= 1'b0;
			din_m_reg <= 1'b0;
			din_s_reg <= 1'b0;
		end else begin
			cs_m_reg <= cs_n_i;
			cs_s_reg <= cs_m_reg;
			sclk_m_reg <= sclk_i;
			sclk_s_reg <= sclk_m_reg;
			sclk_d_reg <= sclk_s_reg;
			din_m_reg <= din_i;
			din_s_reg <= din_m_reg;
		end
	end
	wire fall = sclk_d_reg & ~sclk_s_reg & ~cs_s_reg;
	wire rise = ~sclk_d_reg & sclk_s_reg & ~cs_s_reg;

	reg [4:0] state_reg;
	reg [2:0] bit_reg;
	reg [7:0] shift_reg;
	reg [7:0] out_reg;
	reg [23:0] res_reg;
	reg [4:0] count_reg;
	reg is_read_reg;
	reg [1:0] sleep_cnt_reg;
	reg sleep_pend_reg;
	reg stop_pend_reg;
	reg [15:0] to_cnt_reg;
	reg wr_adv_reg;
	wire [7:0] byte_in = {shift_reg[6:0], din_s_reg};
	wire byte_done = fall && bit_reg == 3'h7;
	wire timeout = timeout_en_i && to_cnt_reg == TIMEOUT_CLKS[15:0] - 16'h1;
	wire in_sync = sync_pin_i;
	wire [7:0] rd_byte = (reg_addr_o > LAST_REG_ADDR[4:0]) ? 8'h00 :
		reg_rdata_i; // RULE_23
	// write address advances only after the first data byte
	wire [4:0] wr_addr = reg_addr_o + {4'h0, wr_adv_reg};
	// first-byte decode, least significant bit ignored where allowed
	wire is_register_read_cmd = byte_in[7:5] == `REGISTER_READ_CMD_HI;
	wire is_register_write_cmd = byte_in[7:5] == `REGISTER_WRITE_CMD_HI;
	wire is_rdata = byte_in[7:1] == `READ_RESULT_CMD_HI;
	wire is_wake = byte_in[7:1] == `RESUME_CMD_HI;
	wire is_sys_off = byte_in == `SYSTEM_OFFSET_CAL_CMD;
	wire is_sys_gain = byte_in == `SYSTEM_GAIN_CAL_CMD;
	wire is_self_off = byte_in == `SELF_OFFSET_CAL_CMD;
	wire is_count = byte_in[7:5] == `COUNT_BYTE_HI;

	// serial timeout: no complete byte within the limit resets the link
	always @(posedge clk_i) begin
		if (reset_i || byte_done || cs_s_reg)
			to_cnt_reg <= 16'h0000;
		else
			to_cnt_reg <= to_cnt_reg + 16'h1;
	end

	// output driven only while the synchronised select is low
	always @(posedge clk_i) begin
		if (reset_i)
			serial_out_en_o <= 1'b0;
		else
			serial_out_en_o <= ~cs_s_reg;
	end

	always @(posedge clk_i) begin
		reg_wr_o <= 1'b0;
		conv_start_o <= 1'b0;
		conv_abort_o <= 1'b0;
		filter_clear_o <= 1'b0;
		defaults_load_o <= 1'b0;
		cal_start_o <= 1'b0;
		result_load_o <= 1'b0;
		if (reset_i) begin
			state_reg <= ST_CMD;
			bit_reg <= 3'h0;
			shift_reg <= 8'h00;
			out_reg <= 8'h00;
			res_reg <= 24'h000000;
			count_reg <= 5'h00;
			is_read_reg <= 1'b0;
			sleep_cnt_reg <= 2'h0;
			sleep_pend_reg <= 1'b0;
			stop_pend_reg <= 1'b0;
			wr_adv_reg <= 1'b0;
			serial_out_o <= 1'b0;
			reg_addr_o <= 5'h00;
			reg_wdata_o <= 8'h00;
			asleep_o <= 1'b0;
			converting_o <= 1'b0;
			int_osc_sel_o <= 1'b1;
			cal_type_o <= 2'h0;
		end else begin
			if (fall)
				shift_reg <= byte_in; // RULE_22
			if (fall)
				bit_reg <= bit_reg + 3'h1;
			if (rise) begin
				serial_out_o <= out_reg[7]; // RULE_22
				out_reg <= {out_reg[6:0], 1'b0};
			end
			// result load blocked during register access
			if (conv_done_i) begin
				res_reg <= result_i;
				if (state_reg == ST_CMD) begin // RULE_07
					out_reg <= result_i[23:16];
					result_load_o <= 1'b1;
				end
				if (single_shot_i || stop_pend_reg) begin // RULE_16
					converting_o <= 1'b0; // RULE_18
					stop_pend_reg <= 1'b0;
				end
			end
			if (sleep_pend_reg) begin
				if (sleep_cnt_reg == `SLEEP_DELAY_CLKS - 1) begin
					asleep_o <= 1'b1; // RULE_11
					sleep_pend_reg <= 1'b0;
				end
				sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
			end
			if (cs_s_reg || timeout) begin
				state_reg <= ST_CMD; // RULE_08 RULE_24
				bit_reg <= 3'h0;
			end else if (byte_done) begin
				case (state_reg)
				ST_CMD: begin
					if (is_register_read_cmd) begin
						reg_addr_o <= byte_in[4:0]; // RULE_05
						is_read_reg <= 1'b1;
						state_reg <= ST_COUNT;
					end else if (!asleep_o &&
						is_register_write_cmd) begin // RULE_13
						reg_addr_o <= byte_in[4:0]; // RULE_06
						is_read_reg <= 1'b0;
						state_reg <= ST_COUNT;
					end else if (is_rdata) begin
						out_reg <= res_reg[23:16]; // RULE_04
						count_reg <= 5'h02;
						state_reg <= ST_RESOUT;
					end else if (is_wake) begin
						asleep_o <= 1'b0; // RULE_09
						sleep_pend_reg <= 1'b0;
					end else if (!asleep_o) begin // RULE_13
						case (byte_in[7:1])
						`SLEEP_ENTRY_CMD_HI: begin
							conv_abort_o <= 1'b1; // RULE_11
							converting_o <= 1'b0;
							stop_pend_reg <= 1'b0;
							sleep_pend_reg <= 1'b1;
							sleep_cnt_reg <= 2'h0;
						end
						`RESET_CMD_HI: begin
							filter_clear_o <= 1'b1; // RULE_14
							defaults_load_o <= 1'b1;
							int_osc_sel_o <= 1'b1;
							converting_o <= 1'b0;
							stop_pend_reg <= 1'b0;
						end
						`START_CMD_HI: begin
							if (!in_sync && !converting_o) begin // RULE_17
								conv_start_o <= 1'b1; // RULE_15
								converting_o <= 1'b1;
							end
						end
						`STOP_CMD_HI: begin
							if (!single_shot_i && converting_o)
								stop_pend_reg <= 1'b1; // RULE_18
						end
						default: begin
							// calibration is only honoured while converting
							if (converting_o) begin
								if (is_sys_off) begin
									cal_start_o <= 1'b1; // RULE_03 RULE_19
									cal_type_o <= `CAL_TYPE_SYS_OFFSET;
								end else if (is_sys_gain) begin
									cal_start_o <= 1'b1; // RULE_03 RULE_20
									cal_type_o <= `CAL_TYPE_SYS_GAIN;
								end else if (is_self_off) begin
									cal_start_o <= 1'b1; // RULE_03 RULE_21
									cal_type_o <= `CAL_TYPE_SELF_OFFSET;
								end
							end
							// idle byte and unknown bytes fall through
						end // RULE_01 RULE_25
						endcase
					end
				end
				ST_COUNT: begin
					if (!is_count)
						state_reg <= ST_CMD; // RULE_25
					else begin
						count_reg <= byte_in[4:0];
						if (is_read_reg) begin
							out_reg <= rd_byte; // RULE_05
							state_reg <= ST_RDOUT;
						end else begin
							wr_adv_reg <= 1'b0;
							state_reg <= ST_WRDATA;
						end
					end
				end
				ST_RDOUT: begin
					if (count_reg == 5'h00)
						state_reg <= ST_CMD; // RULE_24
					else begin
						count_reg <= count_reg - 5'h01;
						reg_addr_o <= reg_addr_o + 5'h01;
					end
				end
				ST_WRDATA: begin
					reg_addr_o <= wr_addr;
					wr_adv_reg <= 1'b1;
					if (wr_addr <= LAST_REG_ADDR[4:0]) begin
						reg_wr_o <= 1'b1; // RULE_06
						reg_wdata_o <= byte_in;
					end
					if (count_reg == 5'h00)
						state_reg <= ST_CMD; // RULE_24
					else
						count_reg <= count_reg - 5'h01;
				end
				ST_RESOUT: begin
					if (count_reg == 5'h00)
						state_reg <= ST_CMD;
					else begin
						count_reg <= count_reg - 5'h01;
						out_reg <= (count_reg == 5'h02) ? res_reg[15:8] :
							res_reg[7:0];
					end
				end
				default: state_reg <= ST_CMD;
				endcase
			end
			// next register byte once address has advanced
			if (state_reg == ST_RDOUT && bit_reg == 3'h0 && rise) begin
				serial_out_o <= rd_byte[7]; // RULE_23
				out_reg <= {rd_byte[6:0], 1'b0};
			end
			// automatic restart in continuous mode: a new start pulse is issued here on each completed conversion unless a stop is pending
			if (conv_done_i && converting_o && !single_shot_i &&
				!stop_pend_reg)
				conv_start_o <= 1'b1; // RULE_15
		end
	end
endmodule // adc_serial_command_decoder
`default_nettype wire

// ---- hdl/cmd_decoder_regs.vh ----
// constants for the serial command decoder
`ifndef CMD_DECODER_REGS_VH
`define CMD_DECODER_REGS_VH
`define IDLE_BYTE_CMD 8'h00
`define RESUME_CMD_HI 7'h01
`define SLEEP_ENTRY_CMD_HI 7'h02
`define RESET_CMD_HI 7'h03
`define START_CMD_HI 7'h04
`define STOP_CMD_HI 7'h05
`define READ_RESULT_CMD_HI 7'h09
`define SYSTEM_OFFSET_CAL_CMD 8'h16
`define SYSTEM_GAIN_CAL_CMD 8'h17
`define SELF_OFFSET_CAL_CMD 8'h19
`define REGISTER_READ_CMD_HI 3'h1
`define REGISTER_WRITE_CMD_HI 3'h2
`define COUNT_BYTE_HI 3'h0
`define SLEEP_DELAY_CLKS 2
`define CAL_TYPE_SYS_OFFSET 2'h0
`define CAL_TYPE_SYS_GAIN 2'h1
`define CAL_TYPE_SELF_OFFSET 2'h2
`endif

// ---- verification/adc_serial_command_decoder_tb.sv ----
// self-checking bench for the serial command decoder
`timescale 1ns/10ps
`default_nettype none
module adc_serial_command_decoder_tb;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic sync_pin_i = 1'b0;
	logic single_shot_i = 1'b0;
	logic conv_done_i = 1'b0;
	wire reg_wr_o, asleep_o, converting_o, conv_start_o, conv_abort_o;
	wire cal_start_o, defaults_load_o, int_osc_sel_o;
	wire [4:0] reg_addr_o;
	wire serial_out;
	wire [7:0] reg_wdata_o;
	wire [1:0] cal_type_o;
	logic [7:0] cnt [5];
	int err_total = 0;
	int n_tests = 0;
	always #2 clk_i = ~clk_i;
	spi_host_model u_spi_host_model ();
	adc_serial_command_decoder u_adc_serial_command_decoder (
		.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(u_spi_host_model.cs_n_o),
		.sclk_i(u_spi_host_model.sclk_o), .din_i(u_spi_host_model.din_o),
		.sync_pin_i(sync_pin_i), .single_shot_i(single_shot_i),
		.timeout_en_i(1'b0), .conv_done_i(conv_done_i),
		.result_i(24'h5a3c96), .reg_rdata_i(8'h3c),
		.serial_out_o(serial_out),
		.serial_out_en_o(), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o),
		.reg_wdata_o(reg_wdata_o), .asleep_o(asleep_o),
		.converting_o(converting_o), .conv_start_o(conv_start_o),
		.conv_abort_o(conv_abort_o), .filter_clear_o(),
		.defaults_load_o(defaults_load_o), .int_osc_sel_o(int_osc_sel_o),
		.cal_start_o(cal_start_o), .cal_type_o(cal_type_o),
		.result_load_o());
	// pulse counters: start, cal, write, abort, defaults
	always @(posedge clk_i) begin
		cnt[0] <= cnt[0] + 8'(conv_start_o);
		cnt[1] <= cnt[1] + 8'(cal_start_o);
		cnt[2] <= cnt[2] + 8'(reg_wr_o);
		cnt[3] <= cnt[3] + 8'(conv_abort_o);
		cnt[4] <= cnt[4] + 8'(defaults_load_o);
	end
	task automatic check(input string what, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmd(input logic [31:0] w, input int nb);
		u_spi_host_model.frame(w, nb, 8);
		repeat (8) @(negedge clk_i);
	endtask
	task automatic done();
		@(posedge clk_i) conv_done_i <= 1'b1;
		@(posedge clk_i) conv_done_i <= 1'b0;
		repeat (4) @(negedge clk_i);
	endtask
	task automatic clr();
		@(negedge clk_i) cnt = '{default: 8'h00};
	endtask
	task automatic t_cont();
		clr();
		cmd(32'h08080000, 2);
		check("start", 8'h01, cnt[0]);
		check("running", 8'h01, converting_o);
		done();
		check("restart", 8'h02, cnt[0]);
		cmd(32'h16171900, 3);
		check("cals", 8'h03, cnt[1]);
		check("cal kind", 8'h02, cal_type_o);
		cmd(32'h0a000000, 1);
		check("stop waits", 8'h01, converting_o);
		done();
		check("stopped", 8'h00, converting_o);
		check("no restart", 8'h02, cnt[0]);
	endtask
	task automatic t_single();
		clr();
		@(posedge clk_i) single_shot_i <= 1'b1;
		cmd(32'h16090b00, 3);
		check("cal idle", 8'h00, cnt[1]);
		check("shot", 8'h01, converting_o);
		done();
		check("shot end", 8'h00, converting_o);
		@(posedge clk_i) single_shot_i <= 1'b0;
		sync_pin_i <= 1'b1;
		cmd(32'h08000000, 1);
		check("sync blocks", 8'h01, cnt[0]);
		@(posedge clk_i) sync_pin_i <= 1'b0;
	endtask
	task automatic t_read();
		clr();
		cmd(32'h25010800, 4);
		check("read", 32'h3c3c, u_spi_host_model.rx_o[15:0]);
		check("blocked", 8'h00, cnt[0]);
		cmd(32'h31010000, 4);
		check("past end", 32'h3c00, u_spi_host_model.rx_o[15:0]);
		cmd(32'h12000000, 4);
		check("result", 32'h5a3c96, u_spi_host_model.rx_o[23:0]);
	endtask
	task automatic t_write();
		clr();
		cmd(32'h4501aabb, 4);
		check("writes", 8'h02, cnt[2]);
		check("addr", 8'h06, reg_addr_o);
		check("data", 8'hbb, reg_wdata_o);
	endtask
	task automatic t_sleep();
		clr();
		cmd(32'h08040845, 4);
		check("abort", 8'h01, cnt[3]);
		check("asleep", 8'h01, asleep_o);
		check("ignored", 8'h01, cnt[0]);
		cmd(32'h02000000, 1);
		check("awake", 8'h00, asleep_o);
		check("idle", 8'h00, converting_o);
	endtask
	task automatic t_reset();
		clr();
		cmd(32'h08060000, 2);
		check("defaults", 8'h01, cnt[4]);
		check("standby", 8'h00, converting_o);
		check("int osc", 8'h01, int_osc_sel_o);
		clr();
		u_spi_host_model.frame(32'h08000000, 1, 4);
		cmd(32'h00ff0000, 2);
		check("abandoned", 8'h00, cnt[0]);
		check("no action", 8'h00, converting_o);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		complete_run();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(negedge clk_i);
		t_cont();
		t_single();
		t_write();
		t_read();
		t_sleep();
		t_reset();
		complete_run();
	end
endmodule // adc_serial_command_decoder_tb
`default_nettype wire

// ---- verification/cmd_decoder_checker.sv ----
// assertion checker for the serial command decoder
`timescale 1ns/10ps
`default_nettype none
module cmd_decoder_checker #(
	parameter LAST_REG_ADDR = 5'h11
) (
	input wire logic clk_i, // clock
	input wire logic reset_i, // reset
	input wire logic cs_n_i, // chip select
	input wire logic serial_out_en_o, // out enable
	input wire logic reg_wr_o, // reg write
	input wire logic [4:0] reg_addr_o, // reg address
	input wire logic asleep_o, // sleep
	input wire logic converting_o, // running
	input wire logic conv_start_o, // start pulse
	input wire logic conv_abort_o, // abort pulse
	input wire logic defaults_load_o, // defaults pulse
	input wire logic int_osc_sel_o, // oscillator
	input wire logic cal_start_o // cal pulse
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence abort_seen; conv_abort_o; endsequence
	sequence sleep_reached; ##[1:6] asleep_o; endsequence
	start_runs_a: assert property (conv_start_o |=> converting_o)
		else $error("start without running");
	sleep_entry_a: assert property (abort_seen |-> sleep_reached)
		else $error("sleep not entered");
	sleep_quiet_a: assert property (asleep_o |->
		!conv_start_o && !cal_start_o && !reg_wr_o)
		else $error("action while asleep");
	cal_running_a: assert property (cal_start_o |-> $past(converting_o))
		else $error("cal while stopped");
	reset_cmd_a: assert property (defaults_load_o |=>
		int_osc_sel_o && !converting_o)
		else $error("reset command state wrong");
	wake_idle_a: assert property ($fell(asleep_o) |-> !converting_o)
		else $error("wake started conversion");
	write_range_a: assert property (reg_wr_o |-> reg_addr_o <= LAST_REG_ADDR)
		else $error("write past last register");
	cs_release_a: assert property (cs_n_i [*4] |=> !serial_out_en_o)
		else $error("output driven with cs high");
endmodule // cmd_decoder_checker
bind adc_serial_command_decoder cmd_decoder_checker #(
	.LAST_REG_ADDR(LAST_REG_ADDR)) u_cmd_decoder_checker (
	.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n_i),
	.serial_out_en_o(serial_out_en_o), .reg_wr_o(reg_wr_o),
	.reg_addr_o(reg_addr_o), .asleep_o(asleep_o),
	.converting_o(converting_o), .conv_start_o(conv_start_o),
	.conv_abort_o(conv_abort_o), .defaults_load_o(defaults_load_o),
	.int_osc_sel_o(int_osc_sel_o), .cal_start_o(cal_start_o));
`default_nettype wire

// ---- verification/spi_host_model.sv ----
// host side of the mode-1 serial link
`timescale 1ns/10ps
`default_nettype none
module spi_host_model;
	logic cs_n_o = 1'b1;
	logic sclk_o = 1'b0;
	logic din_o = 1'b0;
	logic [31:0] rx_o = 32'h0;
	// data set at rising edge, taken by the device at falling edge
	task automatic xfer(input logic [7:0] b, input int nbits);
		for (int i = 7; i > 7 - nbits; i--) begin
			#62.5 sclk_o = 1'b1;
			din_o = b[i];
			#62.5 rx_o = {rx_o[30:0], adc_serial_command_decoder_tb.serial_out};
			sclk_o = 1'b0;
		end
	endtask
	// nb bytes of nbits bits each, all inside one low chip-select span
	task automatic frame(input logic [31:0] w, input int nb, input int nbits);
		cs_n_o = 1'b0;
		for (int k = 0; k < nb; k++) xfer(w[31-8*k -: 8], nbits);
		#100 cs_n_o = 1'b1;
		din_o = 1'b0;
	endtask
endmodule // spi_host_model
`default_nettype wire
